// File: verilog/dpm_pkg.sv
// Package with register map, field layout, reset values and modes of the decode performance monitor.
package dpm_pkg;

	// ==========================================================
	// Register byte offsets.
	localparam logic [4:0] DPM_REG_CTRL = 5'h00;
	localparam logic [4:0] DPM_REG_SETPOINT = 5'h04;
	localparam logic [4:0] DPM_REG_GAP = 5'h08;
	localparam logic [4:0] DPM_REG_STATUS = 5'h0c;
	localparam logic [4:0] DPM_REG_IRQ_STAT = 5'h10;
	localparam logic [4:0] DPM_REG_IRQ_MASK = 5'h14;
	localparam logic [4:0] DPM_REG_COUNT = 5'h18;

	// ==========================================================
	// Field positions and widths.
	localparam int DPM_CTRL_MODE_LSB = 0;
	localparam int DPM_CTRL_TGT_LSB = 4;
	localparam int DPM_CTRL_OUT_LSB = 8;
	localparam int DPM_TGT_W = 4;
	localparam int DPM_OUT_W = 3;
	localparam int DPM_SP_W = 7;
	localparam int DPM_GAP_W = 16;
	localparam int DPM_CNT_W = 16;
	localparam int DPM_ST_LOW = 0;
	localparam int DPM_ST_PERIOD = 1;
	localparam int DPM_ST_CNT_LOW = 2;
	localparam int DPM_ST_MRG_LOW = 3;
	localparam int DPM_IRQ_W = 3;
	localparam int DPM_IRQ_END = 0;
	localparam int DPM_IRQ_LOW = 1;
	localparam int DPM_IRQ_REJ = 2;

	// ==========================================================
	// Limits and reset values.
	localparam logic [15:0] DPM_SP_MAX = 16'h0063;
	localparam logic [15:0] DPM_GAP_MAX = 16'hfa00;
	localparam logic [6:0] DPM_SP_RST = 7'h00;
	localparam logic [15:0] DPM_GAP_RST = 16'h0000;
	localparam logic [3:0] DPM_TGT_RST = 4'h0;
	localparam logic [2:0] DPM_OUT_RST = 3'h0;
	localparam logic [2:0] DPM_IRQ_RST = 3'h0;

	// ==========================================================
	// Indicator modes; code 2'b11 is illegal and acts as disable.
	typedef enum logic [1:0] {
		DPM_OFF = 2'b00,
		DPM_COUNT = 2'b01,
		DPM_MARGIN = 2'b10
	} dpm_mode_t;

	// Trigger period state.
	typedef enum logic {
		DPM_IDLE = 1'b0,
		DPM_PERIOD = 1'b1
	} dpm_per_t;

	// Clamps a written value to a field maximum.
	function automatic logic [15:0] dpm_clamp(input logic [15:0] v, input logic [15:0] lim);
		dpm_clamp = (v > lim) ? lim : v;
	endfunction

endpackage

// File: verilog/dpm_gap_filter.sv
// Inter-symbol no-read gap filter of the decode performance monitor.
`timescale 1ns/10ps
module dpm_gap_filter
	import dpm_pkg::*;
#(
	parameter int GAP_W = DPM_GAP_W
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic enable,
	input wire logic [GAP_W-1:0] gap_cfg,
	input wire logic scan_decode,
	input wire logic scan_noread,
	output logic accept,
	output logic reject
);

	initial begin
		if (GAP_W < 1 || GAP_W > 32) begin
			$error("dpm_gap_filter: GAP_W out of range");
		end
	end

	logic [GAP_W-1:0] gap_cnt;
	logic fresh;
	logic gap_met;

	// A decode passes when no symbol was accepted yet or the no-read gap is long enough; content never matters.
	assign gap_met = fresh || (gap_cnt >= gap_cfg); // [RULE8] [RULE9]
	assign accept = enable && scan_decode && gap_met;
	assign reject = enable && scan_decode && !gap_met;

	// Any decode breaks the run of no-reads, no-reads count up and stop at the configured gap.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			gap_cnt <= '0;
		end else if (enable && scan_decode) begin
			gap_cnt <= '0; // [RULE10]
		end else if (enable && scan_noread && gap_cnt < gap_cfg) begin
			gap_cnt <= gap_cnt + 1'b1; // [RULE10]
		end
	end

	// Remembers that no symbol has been accepted since reset.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fresh <= 1'b1;
		end else if (accept) begin
			fresh <= 1'b0;
		end
	end

	// An accepted symbol followed by one cycle that holds no enabled no-read.
	sequence s_accept_then_quiet;
		accept ##1 !(enable && scan_noread);
	endsequence

	a_accept_clears: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
		accept |=> gap_cnt == '0) else $error("gap counter not cleared after accept");
	a_noread_counts: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
		enable && scan_noread && !scan_decode && gap_cnt < gap_cfg |=> gap_cnt == $past(gap_cnt) + 1'b1)
		else $error("no-read did not advance gap counter");
	a_short_gap_rejects: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
		s_accept_then_quiet ##1 (enable && scan_decode && gap_cfg != '0 && $stable(gap_cfg)) |-> reject)
		else $error("decode accepted without no-read gap");
	a_zero_gap_pass: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
		enable && scan_decode && gap_cfg == '0 |-> accept) else $error("zero gap rejected a decode");

endmodule

// File: verilog/dpm_monitor.sv
// Top module of the decode performance monitor with its Avalon-MM register slave.
`timescale 1ns/10ps

// Operation
// (RULE1) A trigger period runs from trigger-on to trigger-off and decodes are taken only inside it.
// (RULE2) The low limit holds 0 to 99 and means a margin or a per-period count depending on the mode.
// (RULE3) With the indicator disabled the low-performance output never asserts.
// (RULE4) In count mode the output asserts when the decodes of a period are fewer than the low limit.
// (RULE5) In count mode the period count is latched and compared only when the period ends.
// (RULE6) In margin mode the output asserts when the supplied margin is below the low limit.
// (RULE7) The indication energizes a selected output module on a selected target reader while performance is low.
// (RULE8) A new symbol is rejected until the configured number of no-reads, 0 to 64000, has followed the last one.
// (RULE9) An identical symbol is accepted once the gap has passed, since only the gap decides.
// (RULE10) The gap counter clears on a decode, counts no-reads, saturates at the setting, and zero accepts all.
module dpm_monitor
	import dpm_pkg::*;
#(
	parameter int OUT_W = DPM_OUT_W,
	parameter int TGT_W = DPM_TGT_W
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic trig_on,
	input wire logic trig_off,
	input wire logic scan_decode,
	input wire logic scan_noread,
	input wire logic [DPM_SP_W-1:0] margin,
	input wire logic margin_valid,
	output logic decode_en,
	output logic sym_accept,
	output logic sym_reject,
	output logic low_perf,
	output logic [(1<<OUT_W)-1:0] perf_energize,
	output logic [TGT_W-1:0] perf_target,
	output logic irq
);

	initial begin
		if (OUT_W != DPM_OUT_W || TGT_W != DPM_TGT_W) begin
			$error("dpm_monitor: OUT_W and TGT_W must match the register fields");
		end
	end

	// ==========================================================
	// Configuration and state registers.
	dpm_mode_t mode;
	logic [TGT_W-1:0] tgt_sel;
	logic [OUT_W-1:0] out_sel;
	logic [DPM_SP_W-1:0] setpoint;
	logic [DPM_GAP_W-1:0] gap_cfg;
	logic [DPM_IRQ_W-1:0] irq_stat;
	logic [DPM_IRQ_W-1:0] irq_mask;
	dpm_per_t per_state;
	logic [DPM_CNT_W-1:0] cnt_run;
	logic [DPM_CNT_W-1:0] count_latched;
	logic count_low;
	logic margin_low;
	logic acc;
	logic rej;
	logic per_end;
	logic wr_take;
	logic next_low;
	logic [DPM_CNT_W-1:0] next_count;
	logic [DPM_IRQ_W-1:0] irq_set;
	logic [31:0] rd_mux;

	// ==========================================================
	// Gap filter, enabled only inside a trigger period.
	dpm_gap_filter #(
		.GAP_W(DPM_GAP_W)
	) u_gap (
		.clk(clk),
		.sys_rst(sys_rst),
		.enable(per_state == DPM_PERIOD),
		.gap_cfg(gap_cfg),
		.scan_decode(scan_decode),
		.scan_noread(scan_noread),
		.accept(acc),
		.reject(rej)
	);

	// ==========================================================
	// Avalon-MM slave: one wait cycle, then the answer with waitrequest low for one cycle.
	assign wr_take = avs_write && !avs_waitrequest;

	// Drops waitrequest on the cycle after a request is seen and raises it again after that edge.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
		end
	end

	// Read multiplexer; unmapped offsets read as zero.
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (avs_address)
			DPM_REG_CTRL: begin
				rd_mux[DPM_CTRL_MODE_LSB +: 2] = mode;
				rd_mux[DPM_CTRL_TGT_LSB +: DPM_TGT_W] = tgt_sel;
				rd_mux[DPM_CTRL_OUT_LSB +: DPM_OUT_W] = out_sel;
			end
			DPM_REG_SETPOINT: rd_mux[DPM_SP_W-1:0] = setpoint;
			DPM_REG_GAP: rd_mux[DPM_GAP_W-1:0] = gap_cfg;
			DPM_REG_STATUS: begin
				rd_mux[DPM_ST_LOW] = low_perf;
				rd_mux[DPM_ST_PERIOD] = (per_state == DPM_PERIOD);
				rd_mux[DPM_ST_CNT_LOW] = count_low;
				rd_mux[DPM_ST_MRG_LOW] = margin_low;
			end
			DPM_REG_IRQ_STAT: rd_mux[DPM_IRQ_W-1:0] = irq_stat;
			DPM_REG_IRQ_MASK: rd_mux[DPM_IRQ_W-1:0] = irq_mask;
			DPM_REG_COUNT: rd_mux[DPM_CNT_W-1:0] = count_latched;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data is loaded on the edge that lowers waitrequest and stands while it is low.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= rd_mux;
		end
	end

	// Control register: mode, target reader and output module.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode <= DPM_OFF;
			tgt_sel <= DPM_TGT_RST;
			out_sel <= DPM_OUT_RST;
		end else if (wr_take && avs_address == DPM_REG_CTRL) begin
			mode <= dpm_mode_t'(avs_writedata[DPM_CTRL_MODE_LSB +: 2]);
			tgt_sel <= avs_writedata[DPM_CTRL_TGT_LSB +: DPM_TGT_W]; // [RULE7]
			out_sel <= avs_writedata[DPM_CTRL_OUT_LSB +: DPM_OUT_W]; // [RULE7]
		end
	end

	// Low limit, clamped so it never exceeds 99.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			setpoint <= DPM_SP_RST;
		end else if (wr_take && avs_address == DPM_REG_SETPOINT) begin
			setpoint <= DPM_SP_W'(dpm_clamp(avs_writedata[15:0], DPM_SP_MAX)); // [RULE2]
		end
	end

	// No-read gap setting, clamped to 64000.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			gap_cfg <= DPM_GAP_RST;
		end else if (wr_take && avs_address == DPM_REG_GAP) begin
			gap_cfg <= dpm_clamp(avs_writedata[15:0], DPM_GAP_MAX); // [RULE8]
		end
	end

	// ==========================================================
	// Trigger period tracking; trigger-on inside a period and trigger-off outside one are ignored.
	assign per_end = (per_state == DPM_PERIOD) && trig_off;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			per_state <= DPM_IDLE;
		end else begin
			unique case (per_state)
				DPM_IDLE: if (trig_on) begin
					per_state <= DPM_PERIOD; // [RULE1]
				end
				DPM_PERIOD: if (trig_off) begin
					per_state <= DPM_IDLE; // [RULE1]
				end
			endcase
		end
	end

	// Decode attempts are enabled only inside a period.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			decode_en <= 1'b0;
		end else begin
			decode_en <= (per_state == DPM_IDLE) ? trig_on : !trig_off; // [RULE1]
		end
	end

	// Registered accept and reject strobes toward the scan pipeline.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sym_accept <= 1'b0;
			sym_reject <= 1'b0;
		end else begin
			sym_accept <= acc;
			sym_reject <= rej;
		end
	end

	// ==========================================================
	// Per-period decode counter; a decode on the closing cycle still counts.
	assign next_count = (acc && cnt_run != '1) ? cnt_run + 1'b1 : cnt_run;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_run <= '0;
		end else if (per_state == DPM_IDLE) begin
			cnt_run <= '0; // [RULE1]
		end else begin
			cnt_run <= next_count;
		end
	end

	// The count is latched and compared only at the end of the period.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_latched <= '0;
			count_low <= 1'b0;
		end else if (per_end) begin
			count_latched <= next_count; // [RULE5]
			count_low <= next_count < DPM_CNT_W'(setpoint); // [RULE4]
		end
	end

	// Margin comparison on every supplied margin value.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			margin_low <= 1'b0;
		end else if (margin_valid) begin
			margin_low <= margin < setpoint; // [RULE6]
		end
	end

	// ==========================================================
	// Low-performance output and its routing to one output module.
	always_comb begin
		unique case (mode)
			DPM_COUNT: next_low = count_low; // [RULE4]
			DPM_MARGIN: next_low = margin_low; // [RULE6]
			default: next_low = 1'b0; // [RULE3]
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			low_perf <= 1'b0;
			perf_energize <= '0;
			perf_target <= DPM_TGT_RST;
		end else begin
			low_perf <= next_low;
			perf_energize <= next_low ? ((1 << OUT_W)'(1) << out_sel) : '0; // [RULE7]
			perf_target <= tgt_sel; // [RULE7]
		end
	end

	// ==========================================================
	// Interrupts: sticky status, write one to clear, the setting event wins over a clear.
	assign irq_set[DPM_IRQ_END] = per_end;
	assign irq_set[DPM_IRQ_LOW] = next_low && !low_perf;
	assign irq_set[DPM_IRQ_REJ] = rej;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_stat <= DPM_IRQ_RST;
		end else if (wr_take && avs_address == DPM_REG_IRQ_STAT) begin
			irq_stat <= (irq_stat & ~avs_writedata[DPM_IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat <= irq_stat | irq_set;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_mask <= DPM_IRQ_RST;
		end else if (wr_take && avs_address == DPM_REG_IRQ_MASK) begin
			irq_mask <= avs_writedata[DPM_IRQ_W-1:0];
		end
	end

	// The level output follows the next status value so it stays in step with it.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else if (wr_take && avs_address == DPM_REG_IRQ_STAT) begin
			irq <= |(((irq_stat & ~avs_writedata[DPM_IRQ_W-1:0]) | irq_set) & irq_mask);
		end else if (wr_take && avs_address == DPM_REG_IRQ_MASK) begin
			irq <= |((irq_stat | irq_set) & avs_writedata[DPM_IRQ_W-1:0]);
		end else begin
			irq <= |((irq_stat | irq_set) & irq_mask);
		end
	end

	// ==========================================================
	// Checks.
	sequence s_period_end;
		per_state == DPM_PERIOD && trig_off;
	endsequence

	sequence s_count_end;
		mode == DPM_COUNT && per_state == DPM_PERIOD && trig_off && !wr_take;
	endsequence

	// A bus request sampled with waitrequest high.
	sequence s_bus_request;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence

	a_bus_one_wait: assert property (@(posedge clk) disable iff (sys_rst)
		s_bus_request |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer not after one wait cycle");
	a_idle_no_count: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
		per_state == DPM_IDLE |=> cnt_run == '0) else $error("decodes counted outside a period");
	a_idle_no_strobe: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
		per_state == DPM_IDLE |=> !sym_accept && !sym_reject) else $error("symbol strobe outside a period");
	a_decode_window: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
		decode_en == (per_state == DPM_PERIOD)) else $error("decode window out of step with period");
	a_setpoint_range: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
		setpoint <= DPM_SP_W'(DPM_SP_MAX)) else $error("low limit above 99");
	a_disable_quiet: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
		mode != DPM_COUNT && mode != DPM_MARGIN |=> !low_perf && perf_energize == '0)
		else $error("indicator asserted while disabled");
	a_count_compare: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
		s_count_end |=> count_low == (count_latched < DPM_CNT_W'($past(setpoint))) ##1 low_perf == $past(count_low))
		else $error("count mode compare wrong");
	a_count_held: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
		!(per_state == DPM_PERIOD && trig_off) |=> $stable(count_latched) && $stable(count_low))
		else $error("count changed while period running");
	a_period_latch: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
		s_period_end |=> count_latched == $past(next_count)) else $error("period count not latched at its end");
	a_accept_counts: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
		per_state == DPM_PERIOD && !trig_off && acc && cnt_run != '1 |=> cnt_run == $past(cnt_run) + 1'b1)
		else $error("accepted decode not counted");
	a_margin_compare: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
		mode == DPM_MARGIN && margin_valid && !wr_take |=> margin_low == ($past(margin) < $past(setpoint))
		##1 low_perf == $past(margin_low)) else $error("margin mode compare wrong");
	a_energize_route: assert property (@(posedge clk) disable iff (sys_rst) // [RULE7]
		low_perf |-> perf_energize == ((1 << OUT_W)'(1) << $past(out_sel)) && perf_target == $past(tgt_sel))
		else $error("indication not routed to selected output");
	a_target_follows: assert property (@(posedge clk) disable iff (sys_rst) // [RULE7]
		perf_target == $past(tgt_sel)) else $error("target reader not forwarded");
	a_reject_strobe: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
		rej |=> sym_reject && !sym_accept && irq_stat[DPM_IRQ_REJ]) else $error("rejected symbol not reported");
	a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
		irq == |(irq_stat & irq_mask)) else $error("interrupt level out of step with status");

endmodule

// File: testbench/dpm_scan_model.sv
// Behavioural model of the scan pipeline and trigger source that feed the monitor.
`timescale 1ns/10ps
module dpm_scan_model
	import dpm_pkg::*;
(
	input wire logic clk,
	output logic trig_on,
	output logic trig_off,
	output logic scan_decode,
	output logic scan_noread,
	output logic [DPM_SP_W-1:0] margin,
	output logic margin_valid
);
	// All strobes idle from time zero.
	initial begin
		{trig_on, trig_off, scan_decode, scan_noread, margin_valid} = 5'h00;
		margin = 7'h00;
	end

	// Raises {trig_on, trig_off, decode, noread} for exactly one cycle, like one scan or trigger event.
	task automatic pulse(input logic [3:0] m);
		@(posedge clk);
		{trig_on, trig_off, scan_decode, scan_noread} <= m;
		@(posedge clk);
		{trig_on, trig_off, scan_decode, scan_noread} <= 4'h0;
	endtask

	// Presents one margin result; the value is inverted afterwards so a stale value is never reused.
	task automatic send_margin(input logic [DPM_SP_W-1:0] v);
		@(posedge clk);
		margin <= v;
		margin_valid <= 1'b1;
		@(posedge clk);
		margin <= ~v;
		margin_valid <= 1'b0;
	endtask
endmodule

// File: testbench/dpm_monitor_tb_top.sv
// Self-checking testbench of the decode performance monitor.
`timescale 1ns/10ps
module dpm_monitor_tb_top
	import dpm_pkg::*;
;
	// ==========================================================
	// Clock, reset and bus signals.
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [4:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic trig_on, trig_off, scan_decode, scan_noread, margin_valid;
	logic [DPM_SP_W-1:0] margin;
	logic decode_en, sym_accept, sym_reject, low_perf, irq;
	logic [7:0] perf_energize;
	logic [3:0] perf_target;
	int err_total = 0;
	int num_checks = 0;

	// Clock of 100 ns period.
	always #50 clk = ~clk;

	dpm_monitor u_dpm_monitor (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .trig_on(trig_on), .trig_off(trig_off), .scan_decode(scan_decode),
		.scan_noread(scan_noread), .margin(margin), .margin_valid(margin_valid), .decode_en(decode_en),
		.sym_accept(sym_accept), .sym_reject(sym_reject), .low_perf(low_perf), .perf_energize(perf_energize),
		.perf_target(perf_target), .irq(irq));

	dpm_scan_model u_dpm_scan_model (.clk(clk), .trig_on(trig_on), .trig_off(trig_off), .scan_decode(scan_decode),
		.scan_noread(scan_noread), .margin(margin), .margin_valid(margin_valid));

	// ==========================================================
	// Comparison and bus tasks.
	task automatic chk_bit(input string name, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %b, seen %b", name, exp, got);
		end
	endtask

	task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	// One Avalon access, held until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		avs_writedata <= d;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk);
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input string name, input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk_word(name, exp, q);
	endtask

	// One decode scan and the strobes expected one cycle later.
	task automatic dec(input logic acc, input logic rej);
		u_dpm_scan_model.pulse(4'h2);
		#1;
		chk_bit("sym_accept", acc, sym_accept);
		chk_bit("sym_reject", rej, sym_reject);
	endtask

	// Ends a period and checks the indicator one edge after evaluation.
	task automatic end_period(input logic low, input logic [7:0] en);
		u_dpm_scan_model.pulse(4'h4);
		@(posedge clk);
		#1;
		chk_bit("low_perf", low, low_perf);
		chk_word("perf_energize", {24'h0, en}, {24'h0, perf_energize});
	endtask

	// ==========================================================
	// Scenarios.
	task automatic t_regs;
		rd("ctrl", DPM_REG_CTRL, 32'h0);
		rd("setpoint", DPM_REG_SETPOINT, 32'h0);
		rd("gap", DPM_REG_GAP, 32'h0);
		rd("mask", DPM_REG_IRQ_MASK, 32'h0);
		rd("unmapped", 5'h1c, 32'h0);
		wr(DPM_REG_SETPOINT, 32'h7f);
		rd("setpoint", DPM_REG_SETPOINT, 32'h63);
		wr(DPM_REG_GAP, 32'hffff);
		rd("gap", DPM_REG_GAP, 32'hfa00);
		wr(DPM_REG_GAP, 32'h0);
		$display("test regs done, errors %0d", err_total);
	endtask

	task automatic t_count;
		wr(DPM_REG_CTRL, 32'h591);
		wr(DPM_REG_SETPOINT, 32'h3);
		dec(1'b0, 1'b0);
		u_dpm_scan_model.pulse(4'h8);
		#1;
		chk_bit("decode_en", 1'b1, decode_en);
		chk_word("perf_target", 32'h9, {28'h0, perf_target});
		dec(1'b1, 1'b0);
		dec(1'b1, 1'b0);
		chk_bit("low_perf", 1'b0, low_perf);
		end_period(1'b1, 8'h20);
		rd("count", DPM_REG_COUNT, 32'h2);
		u_dpm_scan_model.pulse(4'h8);
		dec(1'b1, 1'b0);
		dec(1'b1, 1'b0);
		dec(1'b1, 1'b0);
		chk_bit("low_perf", 1'b1, low_perf);
		end_period(1'b0, 8'h00);
		$display("test count done, errors %0d", err_total);
	endtask

	task automatic t_gap;
		wr(DPM_REG_GAP, 32'h2);
		u_dpm_scan_model.pulse(4'h8);
		wr(DPM_REG_IRQ_STAT, 32'h7);
		u_dpm_scan_model.pulse(4'h1);
		u_dpm_scan_model.pulse(4'h1);
		dec(1'b1, 1'b0);
		dec(1'b0, 1'b1);
		chk_bit("irq", 1'b0, irq);
		wr(DPM_REG_IRQ_MASK, 32'h4);
		@(posedge clk);
		#1;
		chk_bit("irq", 1'b1, irq);
		u_dpm_scan_model.pulse(4'h1);
		dec(1'b0, 1'b1);
		u_dpm_scan_model.pulse(4'h1);
		u_dpm_scan_model.pulse(4'h1);
		dec(1'b1, 1'b0);
		rd("irq_stat", DPM_REG_IRQ_STAT, 32'h4);
		wr(DPM_REG_IRQ_STAT, 32'h4);
		rd("irq_stat", DPM_REG_IRQ_STAT, 32'h0);
		chk_bit("irq", 1'b0, irq);
		u_dpm_scan_model.pulse(4'h4);
		$display("test gap done, errors %0d", err_total);
	endtask

	task automatic t_margin;
		wr(DPM_REG_CTRL, 32'h592);
		wr(DPM_REG_SETPOINT, 32'h32);
		u_dpm_scan_model.send_margin(7'h31);
		@(posedge clk);
		#1;
		chk_bit("low_perf", 1'b1, low_perf);
		chk_word("perf_energize", 32'h20, {24'h0, perf_energize});
		u_dpm_scan_model.send_margin(7'h32);
		@(posedge clk);
		#1;
		chk_bit("low_perf", 1'b0, low_perf);
		u_dpm_scan_model.send_margin(7'h0a);
		wr(DPM_REG_CTRL, 32'h590);
		@(posedge clk);
		#1;
		chk_bit("low_perf", 1'b0, low_perf);
		rd("status", DPM_REG_STATUS, 32'hc);
		wr(DPM_REG_CTRL, 32'h593);
		u_dpm_scan_model.send_margin(7'h05);
		@(posedge clk);
		#1;
		chk_bit("low_perf", 1'b0, low_perf);
		chk_word("perf_energize", 32'h0, {24'h0, perf_energize});
		$display("test margin done, errors %0d", err_total);
	endtask

	// ==========================================================
	// Verdict and run control.
	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Watchdog sized well beyond the 141 cycles the tests need.
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		wrap_up();
	end

	// Main sequence.
	initial begin
		avs_address <= 5'h00;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= 32'h0000_0000;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs();
		t_count();
		t_gap();
		t_margin();
		wrap_up();
	end
endmodule
